// File: hdl/watchdog_mode_control.sv
// watchdog counter with its write-only mode register, apb slave and irq
// assumes core strobes (first_instr, wdt_instr, halt, stop) are on pclk;
// rc and xin are pin levels, sampled by two flip-flops before use
//
// What this block does
// - rc source taps 3.5, 7, 14, 56 ms
// - xin source taps 128, 256, 512, 2048 ticks
// - halt bit one keeps counting, default one
// - stop bit one keeps counting, default one
// - source bit one picks xin, zero rc
// - mode writes only in 64 cycles window
// - mode register unreadable, index 0x0f
// - permanent option starts watchdog on reset exit
// - watchdog instruction restarts the period
// - otherwise instruction starts it, reset disables
// - permanent with rc cannot be disabled
// - halt and stop bits still gate counting
`timescale 1ns/100ps
`default_nettype none
module watchdog_mode_control #(
  parameter int RC_KHZ = 100, // internal rc frequency in khz
  parameter int CNT_W = 16 // counter width
) (
  input wire logic pclk, // system clock, 25 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic internal_rc_oscillator_in, // internal_rc_oscillator level
  input wire logic xin_in, // external clock pin level
  input wire logic perm_enable_opt, // permanent-enable programming option
  input wire logic first_instr, // pulse, first instruction after reset
  input wire logic stop_recovery, // pulse, stop-mode recovery
  input wire logic wdt_instr, // pulse, watchdog instruction executed
  input wire logic halt_mode, // core in halt
  input wire logic stop_mode, // core in stop
  output logic wdt_reset, // pulse, watchdog reset request
  output logic irq // level interrupt
);
  import wdt_pkg::*;

  // rc tap lengths rounded up to whole rc ticks
  localparam logic [CNT_W-1:0] RC_TAP0 = CNT_W'((RC_TAP0_US * RC_KHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RC_TAP1 = CNT_W'((RC_TAP1_US * RC_KHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RC_TAP2 = CNT_W'((RC_TAP2_US * RC_KHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RC_TAP3 = CNT_W'((RC_TAP3_US * RC_KHZ + 999) / 1000);

  // tick count at which the selected tap expires
  function automatic logic [CNT_W-1:0] tap_limit(input logic [1:0] tap, input logic xin);
    logic [CNT_W-1:0] lim;
    lim = '0;
    if (xin)
    begin
      case (tap)
        2'b00: lim = CNT_W'(XIN_TAP0);
        2'b01: lim = CNT_W'(XIN_TAP1);
        2'b10: lim = CNT_W'(XIN_TAP2);
        default: lim = CNT_W'(XIN_TAP3);
      endcase
    end
    else
    begin
      case (tap)
        2'b00: lim = RC_TAP0;
        2'b01: lim = RC_TAP1;
        2'b10: lim = RC_TAP2;
        default: lim = RC_TAP3;
      endcase
    end
    return lim;
  endfunction

  // two-stage synchronisers for the two clock pins
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic src_prev_q;
  logic [1:0] pins;
  assign pins = {xin_in, internal_rc_oscillator_in};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end
    else
    begin
      pin_s1_q <= pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  // option strap, synchronised then held after reset release
  logic perm_s1_q;
  logic perm_s2_q;
  logic perm_q;
  logic [1:0] perm_age_q;
  logic perm_done_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      perm_s1_q <= 1'b0;
      perm_s2_q <= 1'b0;
      perm_q <= 1'b0;
      perm_age_q <= 2'h0;
      perm_done_q <= 1'b0;
    end
    else
    begin
      perm_s1_q <= perm_enable_opt;
      perm_s2_q <= perm_s1_q;
      perm_age_q <= {perm_age_q[0], 1'b1};
      // latched once, so a strap that moves later cannot arm the watchdog
      if (perm_age_q[1] && !perm_done_q)
      begin
        perm_q <= perm_s2_q;
        perm_done_q <= 1'b1;
      end
    end
  end

  // state registers
  mode_s mode_q;
  mode_s mode_d;
  win_e win_q;
  win_e win_d;
  logic [6:0] win_cnt_q;
  logic [6:0] win_cnt_d;
  logic en_q;
  logic en_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic wdt_reset_q;
  logic [EV_W-1:0] status_q;
  logic [EV_W-1:0] status_d;
  logic [EV_W-1:0] mask_q;
  logic [31:0] prdata_q;

  // bus decode
  logic setup_ph;
  logic wr_en;
  logic hit_mode;
  logic hit_status;
  logic hit_mask;
  logic hit_state;
  logic hit_any;
  assign setup_ph = psel & ~penable;
  assign hit_mode = paddr == MODE_ADDR;
  assign hit_status = paddr == STATUS_ADDR;
  assign hit_mask = paddr == MASK_ADDR;
  assign hit_state = paddr == STATE_ADDR;
  assign hit_any = hit_mode | hit_status | hit_mask | hit_state;
  assign wr_en = psel & penable & pwrite & hit_any;

  // zero wait states: prdata was loaded in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_q;

  // tick of the selected counter source, taken from the second stage
  logic src_now;
  logic tick;
  assign src_now = mode_q.xin_sel ? pin_s2_q[1] : pin_s2_q[0];
  assign tick = src_now & ~src_prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      src_prev_q <= 1'b0;
    else
      src_prev_q <= src_now;
  end

  // counting gate; a stopped xin simply yields no ticks in stop
  logic gate_halt;
  logic gate_stop;
  logic running;
  logic expire;
  assign gate_halt = ~halt_mode | mode_q.run_halt;
  assign gate_stop = ~stop_mode | mode_q.run_stop;
  assign running = en_q & gate_halt & gate_stop;
  assign expire = running & tick & (cnt_q >= tap_limit(mode_q.tap, mode_q.xin_sel) - 1'b1);

  // mode write accepted only while the window is open
  logic mode_wr;
  logic mode_ok;
  assign mode_wr = wr_en & hit_mode;
  assign mode_ok = mode_wr & (win_q == WIN_OPEN);

  // window, enable, counter and mode next state
  always_comb
  begin
    win_d = win_q;
    win_cnt_d = win_cnt_q;
    en_d = en_q;
    cnt_d = cnt_q;
    mode_d = mode_q;
    case (win_q)
      WIN_WAIT:
      begin
        if (first_instr)
        begin
          win_d = WIN_OPEN;
          win_cnt_d = 7'h00;
        end
      end
      WIN_OPEN:
      begin
        win_cnt_d = win_cnt_q + 7'h01;
        if (win_cnt_q == WINDOW_CYCLES - 7'h01)
          win_d = WIN_LOCK;
      end
      WIN_LOCK:
        win_d = WIN_LOCK;
      default:
        win_d = WIN_WAIT;
    endcase
    if (stop_recovery)
      win_d = WIN_WAIT;
    if (mode_ok)
      mode_d = mode_s'({3'h0, pwdata[4:0]});
    if (running && tick)
      cnt_d = cnt_q + 1'b1;
    if (wdt_instr)
    begin
      en_d = 1'b1;
      cnt_d = '0;
    end
    if (expire)
    begin
      // watchdog reset: defaults, window waits, option decides enable
      mode_d = mode_s'(MODE_RST);
      win_d = WIN_WAIT;
      cnt_d = '0;
      en_d = perm_q;
    end
    // permanent option keeps it armed; software has no way to clear it
    if (perm_q)
      en_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_q <= WIN_WAIT;
      win_cnt_q <= 7'h00;
      en_q <= 1'b0;
      cnt_q <= '0;
      mode_q <= mode_s'(MODE_RST);
      wdt_reset_q <= 1'b0;
    end
    else
    begin
      win_q <= win_d;
      win_cnt_q <= win_cnt_d;
      en_q <= en_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      wdt_reset_q <= expire;
    end
  end

  assign wdt_reset = wdt_reset_q;

  // sticky events; a new event wins over a same-cycle clear
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;
  assign ev = {mode_wr & ~mode_ok, expire};
  assign clr = (wr_en & hit_status) ? pwdata[EV_W-1:0] : '0;
  assign status_d = (status_q & ~clr) | ev;
  assign irq = |(status_q & mask_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      status_q <= status_d;
      if (wr_en && hit_mask)
        mask_q <= pwdata[EV_W-1:0];
    end
  end

  // read mux; the mode register always reads back zero
  logic [31:0] rd_state;
  logic [31:0] rd_val;
  assign rd_state = {
    16'(cnt_q),
    12'h000,
    perm_q,
    running,
    win_q == WIN_OPEN,
    en_q
  };
  assign rd_val = hit_status ? 32'(status_q) :
                  hit_mask ? 32'(mask_q) :
                  hit_state ? rd_state :
                  32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (setup_ph)
      prdata_q <= rd_val;
  end

endmodule
`default_nettype wire

// File: hdl/wdt_pkg.sv
// constants, register map and field layout of the watchdog mode block
// assumes a single system clock pclk; rc and xin arrive as slow pin levels
package wdt_pkg;

  // apb word registers; the mode register keeps its printed index 0x0f
  localparam logic [7:0] MODE_IDX = 8'h0f;
  localparam logic [11:0] MODE_ADDR = {2'h0, MODE_IDX, 2'h0};
  localparam logic [11:0] STATUS_ADDR = 12'h040;
  localparam logic [11:0] MASK_ADDR = 12'h044;
  localparam logic [11:0] STATE_ADDR = 12'h048;

  // mode register fields and value after reset
  localparam int TAP_LSB = 0;
  localparam int HALT_BIT = 2;
  localparam int STOP_BIT = 3;
  localparam int XIN_BIT = 4;
  localparam logic [7:0] MODE_RST = 8'h0d;

  // interrupt status bits
  localparam int EV_TIMEOUT = 0;
  localparam int EV_REJECT = 1;
  localparam int EV_W = 2;

  // write window after the first instruction, in system clocks
  localparam logic [6:0] WINDOW_CYCLES = 7'h40;

  // rc tap minimum times in microseconds
  localparam int RC_TAP0_US = 3500;
  localparam int RC_TAP1_US = 7000;
  localparam int RC_TAP2_US = 14000;
  localparam int RC_TAP3_US = 56000;

  // tap lengths when the chain runs from the xin pin, in clock ticks
  localparam logic [15:0] XIN_TAP0 = 16'h0080;
  localparam logic [15:0] XIN_TAP1 = 16'h0100;
  localparam logic [15:0] XIN_TAP2 = 16'h0200;
  localparam logic [15:0] XIN_TAP3 = 16'h0800;

  typedef struct packed {
    logic [2:0] rsvd;
    logic xin_sel;
    logic run_stop;
    logic run_halt;
    logic [1:0] tap;
  } mode_s;

  typedef enum logic [1:0] {
    WIN_WAIT = 2'b00,
    WIN_OPEN = 2'b01,
    WIN_LOCK = 2'b10
  } win_e;

endpackage

// File: bench/watchdog_mode_control_assertions.sv
// port checker for the watchdog mode block
// assumes wdt_pkg addresses; bound into every instance of the block
`timescale 1ns/100ps
`default_nettype none
module watchdog_mode_control_assertions
  import wdt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic perm_enable_opt,
  input wire logic wdt_instr,
  input wire logic wdt_reset,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase and address decode, as a slave would see them
  wire logic acc = psel && penable;
  wire logic hit = paddr == MODE_ADDR || paddr == STATUS_ADDR ||
    paddr == MASK_ADDR || paddr == STATE_ADDR;
  property p_pulse; wdt_reset |=> !wdt_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse too long");
  property p_mode_rd; acc && !pwrite && paddr == MODE_ADDR |-> prdata == '0; endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode read back");
  property p_map; acc && hit |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("error on mapped");
  property p_unmap; acc && !hit |-> pslverr && prdata == '0; endproperty
  a_unmap: assert property (p_unmap) else $error("no error on hole");
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  // a pending expiry may still show one cycle after the refresh
  property p_refresh; wdt_instr ##1 !wdt_reset |-> !wdt_reset [*8]; endproperty
  a_refresh: assert property (p_refresh) else $error("reset after refresh");
  property p_boot; $rose(presetn) && !perm_enable_opt |-> !wdt_reset [*8]; endproperty
  a_boot: assert property (p_boot) else $error("reset while off");
  property p_irq; $rose(irq) |-> wdt_reset || $past(acc && pwrite); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  c_exp: cover property (wdt_reset);
  c_err: cover property (acc && pslverr);
  c_irq: cover property ($rose(irq));
endmodule

bind watchdog_mode_control watchdog_mode_control_assertions chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .perm_enable_opt(perm_enable_opt),
  .wdt_instr(wdt_instr), .wdt_reset(wdt_reset), .irq(irq));
`default_nettype wire

// File: bench/watchdog_mode_control_tb.sv
// self-checking bench for the watchdog mode block, one task a scenario
// assumes wdt_pkg; rc slowed to 20 khz so rc taps stay short
`timescale 1ns/100ps
`default_nettype none
module watchdog_mode_control_tb;
  import wdt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic rc = 0, xin = 0, perm = 0, fi = 0, wi = 0, hm = 0, sm = 0, sr = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, wdt_reset, irq;
  int errors = 0, cmp_count = 0, nres = 0, cyc = 0, b;
  // stop recovery only sends the window back to wait; it is driven in the perm scenario
  watchdog_mode_control #(.RC_KHZ(20)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .internal_rc_oscillator_in(rc), .xin_in(xin),
    .perm_enable_opt(perm), .first_instr(fi), .stop_recovery(sr), .wdt_instr(wi),
    .halt_mode(hm), .stop_mode(sm), .wdt_reset(wdt_reset), .irq(irq));
  // 40 ns clock
  always #20 pclk = ~pclk;
  // count reset pulses mid-cycle, so a task checking at the next edge sees them
  always @(negedge pclk)
  begin
    cyc++;
    if (wdt_reset === 1'b1) nres++;
    if (cyc == 20000)
    begin
      errors++;
      test_done;
    end
  end
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task rst(input logic p);
    presetn <= 0;
    perm <= p;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (6) @(posedge pclk);
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // one idle edge, so outputs settle and the next call never rewrites psel
    @(posedge pclk);
  endtask
  // k 0 first instruction, k 1 watchdog instruction, k 2 stop recovery
  task pul(input int k);
    fi <= (k == 0);
    wi <= (k == 1);
    sr <= (k == 2);
    @(posedge pclk);
    fi <= 0;
    wi <= 0;
    sr <= 0;
  endtask
  // n rising edges on xin (x 1) or rc (x 0), slow enough for the sync
  task tk(input logic x, input int n);
    repeat (n)
    begin
      rc <= !x;
      xin <= x;
      repeat (2) @(posedge pclk);
      rc <= 0;
      xin <= 0;
      repeat (2) @(posedge pclk);
    end
  endtask
  task t_boot;
    rst(0);
    apb(0, STATE_ADDR, 0);
    chk("state", rd, 32'h0);
    apb(0, MODE_ADDR, 0);
    chk("mode rd", rd, 32'h0);
    apb(0, 12'h000, 0);
    chk("slverr", {31'h0, er}, 32'h1);
    chk("ready", {31'h0, pready}, 32'h1);
    $display("boot done");
  endtask
  task t_window;
    pul(0);
    apb(1, MASK_ADDR, 32'h3);
    apb(1, MODE_ADDR, 32'h1c);
    repeat (64) @(posedge pclk);
    apb(1, MODE_ADDR, 32'h0);
    apb(0, STATUS_ADDR, 0);
    chk("reject", rd, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1, STATUS_ADDR, 32'h2);
    pul(1);
    b = nres;
    tk(1, 127);
    chk("early", nres - b, 0);
    tk(1, 3);
    chk("expire", nres - b, 1);
    apb(0, STATE_ADDR, 0);
    chk("off", rd & 32'h3, 32'h0);
    apb(0, STATUS_ADDR, 0);
    chk("timeout", rd, 32'h1);
    apb(1, STATUS_ADDR, 32'h1);
    chk("irq clr", {31'h0, irq}, 32'h0);
    $display("window done");
  endtask
  task t_refresh;
    pul(0);
    apb(1, MODE_ADDR, 32'h10);
    pul(1);
    b = nres;
    tk(1, 100);
    pul(1);
    tk(1, 100);
    hm <= 1;
    tk(1, 200);
    hm <= 0;
    tk(1, 26);
    chk("refresh", nres - b, 0);
    tk(1, 4);
    chk("halt", nres - b, 1);
    $display("refresh done");
  endtask
  // mode is back at its reset value: rc, 7000 us tap, runs in stop
  task t_rc;
    pul(1);
    sm <= 1;
    b = nres;
    tk(0, 139);
    chk("rc early", nres - b, 0);
    tk(0, 3);
    chk("rc tap", nres - b, 1);
    sm <= 0;
    $display("rc done");
  endtask
  task t_perm;
    rst(1);
    apb(0, STATE_ADDR, 0);
    chk("perm", rd & 32'h9, 32'h9);
    // lock the window, then stop recovery and a first instruction reopen it
    pul(0);
    repeat (70) @(posedge pclk);
    apb(1, MODE_ADDR, 32'h0d);
    pul(2);
    apb(1, STATUS_ADDR, 32'h2);
    pul(0);
    apb(1, MODE_ADDR, 32'h12);
    apb(0, STATUS_ADDR, 0);
    chk("recover", rd, 32'h0);
    pul(1);
    b = nres;
    tk(1, 511);
    chk("x512 early", nres - b, 0);
    tk(1, 2);
    chk("x512", nres - b, 1);
    apb(0, STATE_ADDR, 0);
    chk("perm kept", rd & 32'h9, 32'h9);
    $display("perm done");
  endtask
  // main sequence
  initial
  begin
    t_boot;
    t_window;
    t_refresh;
    t_rc;
    t_perm;
    test_done;
  end
endmodule
`default_nettype wire
